// [inc/gpio_port_pkg.sv]
package gpio_port_pkg;
  localparam int PORT_WIDTH = 8;
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_VALUE_RESET = 8'h00;
  localparam logic [7:0] MCU_CONTROL_RESET = 8'h00;
  localparam int PULLUP_DISABLE_BIT = 4;
  localparam logic [7:0] MCU_CONTROL_RW_MASK = 8'h10;
  localparam logic [1:0] ADDR_PIN_INPUT = 2'h0;
  localparam logic [1:0] ADDR_DIRECTION = 2'h1;
  localparam logic [1:0] ADDR_OUTPUT_VALUE = 2'h2;
  localparam logic [1:0] ADDR_MCU_CONTROL = 2'h3;
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
endpackage

// [inc/pin_ctrl_if.sv]
`timescale 1ns/1ps
interface pin_ctrl_if #(parameter int W = 8);
  logic [W-1:0] direction;
  logic [W-1:0] output_value;
  logic pullup_disable;
  logic [W-1:0] pad_in;
  logic [W-1:0] pad_out;
  logic [W-1:0] pad_oe;
  logic [W-1:0] pullup_en;
  modport ctrl (output direction, output output_value, output pullup_disable, input pad_out,
    input pad_oe, input pullup_en);
  modport pad (input direction, input output_value, input pullup_disable, output pad_out,
    output pad_oe, output pullup_en);
endinterface

// [hdl/pin_driver.sv]
`timescale 1ns/1ps
module pin_driver
  import gpio_port_pkg::*;
#(
  parameter int W = 8
) (
  // Reset.
  input wire logic resetn_i,
  // Control.
  pin_ctrl_if.pad ctl
);
  wire logic [W-1:0] as_input;
  assign as_input = ~ctl.direction;
  assign ctl.pad_oe = resetn_i ? ctl.direction : '0;
  assign ctl.pad_out = ctl.output_value & ctl.direction;
  assign ctl.pullup_en = (resetn_i && !ctl.pullup_disable) ?
    (as_input & ctl.output_value) : '0;
endmodule // pin_driver

// [hdl/general_digital_io_port.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Direction one makes a pin output, zero makes it input.
// - Input pin with output value one gets pull-up unless globally disabled.
// - Pull-up off when output value is zero or pin is output.
// - Reset tri-states all pins at once, with no clock needed.
// - Output pin drives the level of its output value bit.
// - Writing one to pin input register toggles output value bit.
// - Global pull-up disable turns off every pull-up.
// - Pin levels are read back through latch plus flip-flop synchronizer.
// - Latch transparent while clock high; flip-flop loads on rising edge.
// - An external edge shows after half to one and a half periods.
// - A written pin value reads back one period later; software waits.
// - Deep sleep clamps digital inputs to ground.
// - Pins with enabled external interrupt are not clamped in sleep.
// - Clamped high pin with edge sense but disabled sets flag on wake.
// - Pull-ups stay off while reset is active.
// - Global pull-up disable is bit 4 of MCU control, resets zero.
module general_digital_io_port
  import gpio_port_pkg::*;
#(
  parameter int W = PORT_WIDTH
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // CPU I/O space.
  input wire logic [1:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Sleep and external interrupt.
  input wire logic sleep_clamp_i,
  input wire logic [W-1:0] ext_int_enable_i,
  input wire logic [W-1:0] ext_int_edge_sense_i,
  output logic [W-1:0] ext_int_wake_flag_o,
  // Pins.
  input wire logic [W-1:0] pad_i,
  output logic [W-1:0] pad_o,
  output logic [W-1:0] pad_oe_o,
  output logic [W-1:0] pullup_en_o,
  output logic pullup_disable_o
);
  pin_ctrl_if #(.W(W)) ctl ();
  logic [W-1:0] direction;
  logic [W-1:0] output_value;
  logic [7:0] mcu_control;
  logic [W-1:0] sync_latch;
  logic [W-1:0] pin_input;
  logic [W-1:0] clamped_q;
  logic sleep_q;
  logic [1:0] wake_dly;
  logic [7:0] rdata;
  wire logic wr_pin = io_wr_i && (io_addr_i == ADDR_PIN_INPUT);
  wire logic wr_dir = io_wr_i && (io_addr_i == ADDR_DIRECTION);
  wire logic wr_out = io_wr_i && (io_addr_i == ADDR_OUTPUT_VALUE);
  wire logic wr_mcu = io_wr_i && (io_addr_i == ADDR_MCU_CONTROL);
  wire logic [W-1:0] toggle_mask = wr_pin ? io_wdata_i[W-1:0] : '0;
  wire logic [W-1:0] clamp = sleep_clamp_i ? ~ext_int_enable_i : '0;
  wire logic [W-1:0] schmitt_in = pad_i & ~clamp;
  wire logic [W-1:0] next_output_value =
    (wr_out ? io_wdata_i[W-1:0] : output_value) ^ toggle_mask;
  wire logic [W-1:0] wake_rise = clamped_q & ~ext_int_enable_i & ext_int_edge_sense_i;

  assign ctl.direction = direction;
  assign ctl.output_value = output_value;
  assign ctl.pullup_disable = mcu_control[PULLUP_DISABLE_BIT];

  pin_driver #(.W(W)) u_drv (
    .resetn_i(resetn_i),
    .ctl(ctl)
  );

  assign pad_o = ctl.pad_out;
  assign pad_oe_o = ctl.pad_oe;
  assign pullup_en_o = ctl.pullup_en;
  assign pullup_disable_o = ctl.pullup_disable;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      direction <= DIRECTION_RESET;
      output_value <= OUTPUT_VALUE_RESET;
      mcu_control <= MCU_CONTROL_RESET;
    end else begin
      if (wr_dir) begin
        direction <= io_wdata_i[W-1:0];
      end
      output_value <= next_output_value;
      if (wr_mcu) begin
        mcu_control <= io_wdata_i & MCU_CONTROL_RW_MASK;
      end
    end
  end

  // Sync latch is transparent while the clock is high.
  // Non-blocking, so the flip-flop at the opening edge still takes the held value.
  always_latch begin
    if (clk_sys_i) begin
      sync_latch <= schmitt_in;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_input <= '0;
    end else begin
      pin_input <= sync_latch;
    end
  end

  // Wake detect: a clamped high pin with edge sense rises when the clamp lifts.
  // The flag waits two cycles so that the synchronizer shows the unclamped level.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sleep_q <= 1'b0;
      wake_dly <= 2'h0;
      clamped_q <= '0;
      ext_int_wake_flag_o <= '0;
    end else begin
      sleep_q <= sleep_clamp_i;
      wake_dly <= {wake_dly[0], sleep_q && !sleep_clamp_i};
      if (sleep_clamp_i && !sleep_q) begin
        clamped_q <= ~ext_int_enable_i;
      end
      ext_int_wake_flag_o <= wake_dly[1] ? (wake_rise & pin_input) : '0;
    end
  end

  always_comb begin
    rdata = 8'h00;
    unique case (io_addr_i)
      ADDR_PIN_INPUT: rdata[W-1:0] = pin_input;
      ADDR_DIRECTION: rdata[W-1:0] = direction;
      ADDR_OUTPUT_VALUE: rdata[W-1:0] = output_value;
      ADDR_MCU_CONTROL: rdata = mcu_control;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      io_rdata_o <= rdata;
    end
  end

  property toggle_p;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (wr_pin && !wr_out) |=> (output_value == ($past(output_value) ^ $past(io_wdata_i[W-1:0])));
  endproperty
  toggle_write_a: assert property (toggle_p) else $error("toggle write wrong");

  pullup_rule_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    pullup_en_o == (~direction & output_value & {W{!mcu_control[PULLUP_DISABLE_BIT]}}))
    else $error("pullup enable wrong");

  pullup_output_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (pullup_en_o & (direction | ~output_value)) == '0) else $error("pullup on output");

  drive_dir_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(direction[0]) |-> pad_oe_o[0]) else $error("pin not driven");

  drive_value_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (pad_o & pad_oe_o) == (output_value & direction)) else $error("drive value wrong");

  global_disable_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $past(wr_mcu && io_wdata_i[PULLUP_DISABLE_BIT]) |-> pullup_en_o == '0)
    else $error("global pullup disable ignored");

  sequence readback_write_s;
    (wr_out || wr_pin) && !sleep_clamp_i;
  endsequence
  sequence readback_quiet_s;
    !wr_out && !wr_pin && !wr_dir && !sleep_clamp_i;
  endsequence
  property readback_p;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      readback_write_s ##1 readback_quiet_s |=>
      ((pin_input ^ $past(output_value)) & $past(direction) & ~(pad_i ^ pad_o)) == '0;
  endproperty
  readback_delay_a: assert property (readback_p) else $error("readback delay wrong");

  sleep_clamp_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (sleep_clamp_i && ext_int_enable_i == '0) [*2] |=> pin_input == '0)
    else $error("clamp failed");

  wake_flag_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ext_int_wake_flag_o != '0) |-> $past(wake_dly[1]))
    else $error("wake flag outside wake");

  oe_match_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    pad_oe_o == direction) else $error("output enable wrong");

  reset_tristate_a: assert property (@(posedge clk_sys_i)
    !resetn_i |-> (pad_oe_o == '0) && (pullup_en_o == '0))
    else $error("pins active in reset");
endmodule // general_digital_io_port

// [test/pin_partner.sv]
`timescale 1ns/1ps
module pin_partner (
  // Clock.
  input wire logic clk_sys_i,
  // Pads from the port.
  input wire logic [7:0] pad_o_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] pullup_en_i,
  // Outside drivers.
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pad_i_o
);
  logic [7:0] float_q = 8'h55;
  // An undriven pin wanders, so a stale level is never taken for a real one.
  always @(posedge clk_sys_i) float_q <= ~float_q;
  assign pad_i_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ext_en_i & ext_val_i) |
    (~pad_oe_i & ~ext_en_i & (pullup_en_i | float_q));
endmodule // pin_partner

// [test/general_digital_io_port_tb.sv]
`timescale 1ns/1ps
module general_digital_io_port_tb;
  import gpio_port_pkg::*;
  logic clk = 0, rstn = 0, wr_s = 0, rd_s = 0, slp = 0, global_pullup_disable;
  logic [1:0] addr = 0;
  logic [7:0] wd = 0, rdat, ie = 0, es = 0, wf, pin, po, poe, pu, exe = 0, exv = 0, q;
  int error_cnt = 0, tests_run = 0;
  initial forever #4 clk = ~clk;
  general_digital_io_port i_general_digital_io_port (.clk_sys_i(clk), .resetn_i(rstn),
    .io_addr_i(addr), .io_wr_i(wr_s), .io_rd_i(rd_s), .io_wdata_i(wd), .io_rdata_o(rdat),
    .sleep_clamp_i(slp), .ext_int_enable_i(ie), .ext_int_edge_sense_i(es),
    .ext_int_wake_flag_o(wf), .pad_i(pin), .pad_o(po), .pad_oe_o(poe), .pullup_en_o(pu),
    .pullup_disable_o(global_pullup_disable));
  pin_partner i_pin_partner (.clk_sys_i(clk), .pad_o_i(po), .pad_oe_i(poe),
    .pullup_en_i(pu), .ext_en_i(exe), .ext_val_i(exv), .pad_i_o(pin));
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
    tests_run++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk) addr = a; wd = d; wr_s = 1;
    @(negedge clk) wr_s = 0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] r);
    @(negedge clk) addr = a; rd_s = 1;
    @(negedge clk) rd_s = 0; r = rdat;
  endtask
  task automatic t_reset;
    chk(poe, 8'h00, 8'hff);
    chk(pu, 8'h00, 8'hff);
    rd(ADDR_DIRECTION, q); chk(q, DIRECTION_RESET, 8'hff);
    rd(ADDR_OUTPUT_VALUE, q); chk(q, OUTPUT_VALUE_RESET, 8'hff);
    rd(ADDR_MCU_CONTROL, q); chk(q, 8'h00, 8'hff);
  endtask
  task automatic t_config;
    wr(ADDR_OUTPUT_VALUE, 8'h35);
    chk(pu, 8'h35, 8'hff);
    wr(ADDR_DIRECTION, 8'h0f);
    chk(poe, 8'h0f, 8'hff);
    chk(po, 8'h05, 8'h0f);
    chk(pu, 8'h30, 8'hff);
    @(negedge clk);
    rd(ADDR_PIN_INPUT, q); chk(q, 8'h35, 8'h3f);
  endtask
  task automatic t_pud;
    wr(ADDR_MCU_CONTROL, 8'hff);
    rd(ADDR_MCU_CONTROL, q); chk(q, 8'h10, 8'hff);
    chk(pu, 8'h00, 8'hff);
    chk({7'h00, global_pullup_disable}, 8'h01, 8'hff);
    wr(ADDR_MCU_CONTROL, 8'h00);
    chk(pu, 8'h30, 8'hff);
  endtask
  task automatic t_toggle;
    wr(ADDR_PIN_INPUT, 8'h81);
    rd(ADDR_OUTPUT_VALUE, q); chk(q, 8'hb4, 8'hff);
    chk(po, 8'h04, 8'h0f);
    chk(pu, 8'hb0, 8'hff);
    @(negedge clk) exe = 8'hc0; exv = 8'h40;
    @(negedge clk);
    rd(ADDR_PIN_INPUT, q); chk(q, 8'h44, 8'hcf);
  endtask
  task automatic t_sleep;
    logic [7:0] acc = 0;
    wr(ADDR_DIRECTION, 8'h00);
    @(negedge clk) exe = 8'hff; exv = 8'hff; ie = 8'h80; es = 8'h01; slp = 1;
    @(negedge clk);
    @(negedge clk);
    rd(ADDR_PIN_INPUT, q); chk(q, 8'h80, 8'hff);
    @(negedge clk) ie = 8'h00;
    @(negedge clk);
    rd(ADDR_PIN_INPUT, q); chk(q, 8'h00, 8'hff);
    @(negedge clk) slp = 0;
    repeat (4) @(negedge clk) acc = acc | wf;
    chk(acc, 8'h01, 8'hff);
  endtask
  task automatic t_async;
    wr(ADDR_DIRECTION, 8'h1f);
    wr(ADDR_OUTPUT_VALUE, 8'ha4);
    chk(po, 8'h04, 8'h1f);
    @(negedge clk) #2 rstn = 0;
    #1 chk(poe, 8'h00, 8'hff);
    chk(pu, 8'h00, 8'hff);
    @(negedge clk) rstn = 1;
    rd(ADDR_DIRECTION, q); chk(q, 8'h00, 8'hff);
    rd(ADDR_OUTPUT_VALUE, q); chk(q, OUTPUT_VALUE_RESET, 8'hff);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1;
    t_reset();
    t_config();
    t_pud();
    t_toggle();
    t_sleep();
    t_async();
    final_report();
  end
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
endmodule // general_digital_io_port_tb
